// >>> hdl/mdr_pkg.sv
// Overview of operation
// R01 - Each mode change updates chosen register bits by hardware per a fixed table.
// R02 - A serial access under way at a mode change is discarded; hardware wins.
// R03 - Off loads defaults: rate 101, masks all ones, mode 100, listed flags one.
// R04 - Mode field reads 100 standby, 111 normal, 001 sleep; overtemp leaves it.
// R05 - Forced sleep clears all event and summary flags and selective wake bits.
// R06 - Forced sleep sets bus wake enable, both wake pin enables and forced status.
// R07 - Transmitter active status is live only in normal mode, else zero.
// R08 - Identity register is read only, fixed per variant, ignores writes.
// R09 - First byte holds 7-bit address and read flag; reads ignore incoming data (code: reads past 32 bits echo SDI on SDO).
// R10 - Writes not 16, 24 or 32 bits long abort and set the serial failure flag.
package mdr_pkg;
  typedef enum logic [5:0] {
    MODE_OFF      = 6'h01,
    MODE_STANDBY  = 6'h02,
    MODE_NORMAL   = 6'h04,
    MODE_SLEEP    = 6'h08,
    MODE_OVERTEMP = 6'h10,
    MODE_FSLEEP   = 6'h20
  } mdr_mode_e;

  // register offsets
  localparam logic [6:0] ADDR_MODE_CTRL  = 7'h01;
  localparam logic [6:0] ADDR_MAIN_STS   = 7'h03;
  localparam logic [6:0] ADDR_CAN_CTRL   = 7'h20;
  localparam logic [6:0] ADDR_TRX_STS    = 7'h22;
  localparam logic [6:0] ADDR_TRX_EN     = 7'h23;
  localparam logic [6:0] ADDR_RATE       = 7'h26;
  localparam logic [6:0] ADDR_FRAME_CTRL = 7'h2F;
  localparam logic [6:0] ADDR_WAKE_EN    = 7'h4C;
  localparam logic [6:0] ADDR_EV_SUM     = 7'h60;
  localparam logic [6:0] ADDR_SYS_EV     = 7'h61;
  localparam logic [6:0] ADDR_TRX_EV     = 7'h63;
  localparam logic [6:0] ADDR_WAKE_EV    = 7'h64;
  localparam logic [3:0] ADDR_DMASK_HI   = 4'hD;
  localparam logic [6:0] ADDR_ID         = 7'h7E;

  // field positions
  localparam int POS_FORCED_SLEEP = 7;
  localparam int POS_NOT_NORMAL   = 5;
  localparam int POS_SW_CFG_OK    = 5;
  localparam int POS_SW_EN        = 4;
  localparam int POS_TX_ACTIVE    = 7;
  localparam int POS_SW_ERR       = 6;
  localparam int POS_SILENCE_STS  = 3;
  localparam int POS_WAKEUP_EN    = 0;
  localparam int POS_RISE_EN      = 1;
  localparam int POS_FALL_EN      = 0;
  localparam int POS_WAKEPIN_SUM  = 3;
  localparam int POS_TRX_SUM      = 2;
  localparam int POS_SYS_SUM      = 0;
  localparam int POS_POWER_ON     = 4;
  localparam int POS_OTW          = 2;
  localparam int POS_SERIAL_FAIL  = 1;
  localparam int POS_FRAME_ERR    = 5;
  localparam int POS_SILENCE_EV   = 4;
  localparam int POS_FAIL_EV      = 1;
  localparam int POS_WAKE_EV      = 0;
  localparam int POS_RISE_EV      = 1;
  localparam int POS_FALL_EV      = 0;

  // writable bits per register
  localparam logic [7:0] WMASK_MODE  = 8'h07;
  localparam logic [7:0] WMASK_CAN   = 8'h30;
  localparam logic [7:0] WMASK_TRXEN = 8'h01;
  localparam logic [7:0] WMASK_RATE  = 8'h07;
  localparam logic [7:0] WMASK_FRAME = 8'h40;
  localparam logic [7:0] WMASK_WAKE  = 8'h03;

  // reset values and mode field codes
  localparam logic [7:0] MC_STANDBY = 8'h04;
  localparam logic [7:0] MC_NORMAL  = 8'h07;
  localparam logic [7:0] MC_SLEEP   = 8'h01;
  localparam logic [7:0] RST_MODE   = MC_STANDBY;
  localparam logic [7:0] RST_MAIN   = 8'h20;
  localparam logic [7:0] RST_RATE   = 8'h05;
  localparam logic [7:0] RST_FRAME  = 8'h40;
  localparam logic [7:0] RST_SYS    = 8'h10;
  localparam logic [7:0] RST_SUM    = 8'h01;
  localparam logic [7:0] RST_DMASK  = 8'hFF;

  // serial frame lengths in bits
  localparam logic [5:0] FRAME_BITS_16 = 6'h10;
  localparam logic [5:0] FRAME_BITS_24 = 6'h18;
  localparam logic [5:0] FRAME_BITS_32 = 6'h20;
  localparam logic [5:0] FRAME_BITS_SAT = 6'h21;
endpackage : mdr_pkg

// >>> hdl/mdr_spi_frame.sv
`timescale 1ns/1ps
`default_nettype none
module mdr_spi_frame (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sck,
  input  wire logic        scsn,
  input  wire logic        sdi,
  input  wire logic        abort_i,
  input  wire logic [7:0]  rd_data_i,
  output logic             sdo_o,
  output logic             live_o,
  output logic [6:0]       rd_addr_o,
  output logic             wr_stb_o,
  output logic [6:0]       wr_addr_o,
  output logic [23:0]      wr_data_o,
  output logic [1:0]       wr_bytes_o,
  output logic             fail_o
);
  logic        sck_q, act_q, act_d, dead_q, dead_d, ro_q, ro_d, sdo_q, sdo_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [7:0]  shi_q, shi_d, sho_q, sho_d;
  logic [6:0]  addr_q, addr_d;
  logic [23:0] dat_q, dat_d;
  logic        rise, fall, len_ok;

  // sample on falling edge, shift out on rising edge
  assign rise   = sck & ~sck_q;
  assign fall   = ~sck & sck_q;
  assign len_ok = (cnt_q == mdr_pkg::FRAME_BITS_16) || (cnt_q == mdr_pkg::FRAME_BITS_24) ||
                  (cnt_q == mdr_pkg::FRAME_BITS_32);
  assign live_o     = act_q & ~dead_q;
  assign rd_addr_o  = addr_q + {5'h00, 2'(cnt_q[4:3] - 2'h1)};
  assign wr_addr_o  = addr_q;
  assign wr_data_o  = dat_q;
  assign wr_bytes_o = 2'(cnt_q[5:3] - 3'h1);
  assign sdo_o      = sdo_q;

  // frame tracking; commit or fail decided when select rises
  always_comb begin
    act_d = act_q; dead_d = dead_q; ro_d = ro_q; sdo_d = sdo_q;
    cnt_d = cnt_q; shi_d = shi_q; sho_d = sho_q; addr_d = addr_q; dat_d = dat_q;
    wr_stb_o = 1'b0;
    fail_o   = 1'b0;
    if (scsn) begin
      if (act_q && !dead_q && !ro_q && (cnt_q != 6'h00)) begin
        wr_stb_o = len_ok;
        fail_o   = !len_ok; // [R10]
      end
      act_d = 1'b0; dead_d = 1'b0; cnt_d = 6'h00; ro_d = 1'b0;
      sho_d = 8'h00; sdo_d = 1'b0;
    end else begin
      act_d = 1'b1;
      if (abort_i) begin
        dead_d = 1'b1; // [R02]
      end
      if (fall) begin
        shi_d = {shi_q[6:0], sdi};
        cnt_d = (cnt_q == mdr_pkg::FRAME_BITS_SAT) ? cnt_q : cnt_q + 6'h01;
        if (cnt_q[2:0] == 3'h7) begin
          if (cnt_q[5:3] == 3'h0) begin
            addr_d = shi_q[6:0]; // [R09]
            ro_d   = sdi;
          end else if (!ro_q) begin // data of a read is dropped [R09]
            case (cnt_q[5:3])
              3'h1:    dat_d[7:0]   = {shi_q[6:0], sdi};
              3'h2:    dat_d[15:8]  = {shi_q[6:0], sdi};
              3'h3:    dat_d[23:16] = {shi_q[6:0], sdi};
              default: dat_d = dat_q;
            endcase
          end
        end
      end
      if (rise) begin
        if (ro_q && (cnt_q >= mdr_pkg::FRAME_BITS_32)) begin
          sdo_d = sdi; // long reads echo the input stream
        end else if ((cnt_q[2:0] == 3'h0) && (cnt_q != 6'h00) && (cnt_q < mdr_pkg::FRAME_BITS_32)) begin
          sdo_d = rd_data_i[7];
          sho_d = {rd_data_i[6:0], 1'b0};
        end else begin
          sdo_d = sho_q[7];
          sho_d = {sho_q[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b0; act_q <= 1'b0; dead_q <= 1'b0; ro_q <= 1'b0; sdo_q <= 1'b0;
      cnt_q <= 6'h00; shi_q <= 8'h00; sho_q <= 8'h00; addr_q <= 7'h00; dat_q <= 24'h000000;
    end else begin
      sck_q <= sck; act_q <= act_d; dead_q <= dead_d; ro_q <= ro_d; sdo_q <= sdo_d;
      cnt_q <= cnt_d; shi_q <= shi_d; sho_q <= sho_d; addr_q <= addr_d; dat_q <= dat_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  read_no_write_a: assert property (ro_q |-> !wr_stb_o) else $error("write committed on a read"); // [R09]
  bad_len_a: assert property (scsn && act_q && !dead_q && !ro_q && cnt_q == 6'h14 |-> fail_o)
    else $error("odd length write not failed"); // [R10]
  abort_quiet_a: assert property (abort_i && !scsn |=> !wr_stb_o && !fail_o)
    else $error("aborted frame still acted"); // [R02]
endmodule : mdr_spi_frame
`default_nettype wire

// >>> hdl/mdr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module mdr_regs #(
  parameter logic [7:0] DEVICE_ID = 8'h5A // arbitrary value
) (
  input  wire logic       REF_CLK,
  input  wire logic       NRST,
  input  wire logic       SCK,
  input  wire logic       SCSN,
  input  wire logic       SDI,
  output logic            SDO,
  input  wire logic [5:0] MODE,
  input  wire logic       TX_ACTIVE,
  input  wire logic       BUS_SILENT,
  input  wire logic       SW_ERROR,
  input  wire logic       EV_BUS_SILENCE,
  input  wire logic       EV_BUS_FAIL,
  input  wire logic       EV_BUS_WAKE,
  input  wire logic       EV_OTW,
  input  wire logic       EV_WAKE_RISE,
  input  wire logic       EV_WAKE_FALL,
  input  wire logic       EV_FRAME_ERR,
  output logic [2:0]      MODE_REQ,
  output logic [2:0]      BUS_RATE,
  output logic            BUS_WAKE_EN,
  output logic            WAKE_RISE_EN,
  output logic            WAKE_FALL_EN,
  output logic            SEL_WAKE_EN,
  output logic            MATCH_DIS
);
  logic [5:0]      mode_q;
  logic            mode_chg, in_normal, in_off;
  logic [7:0]      mc_q, mc_d, main_q, main_d, can_q, can_d, trxen_q, trxen_d;
  logic [7:0]      rate_q, rate_d, frame_q, frame_d, wake_q, wake_d;
  logic [7:0]      sum_q, sum_d, sys_q, sys_d, trx_q, trx_d, wpev_q, wpev_d;
  logic [7:0][7:0] dm_q, dm_d;
  logic [7:0]      sys_set, trx_set, wp_set, rd_data, trx_sts;
  logic [6:0]      rd_addr, wr_addr;
  logic [23:0]     wr_data;
  logic [1:0]      wr_bytes;
  logic            wr_stb, spi_fail, spi_live;

  assign mode_chg  = (MODE != mode_q); // [R01]
  assign in_normal = (mode_q == mdr_pkg::MODE_NORMAL);
  assign in_off    = (mode_q == mdr_pkg::MODE_OFF);

  // a mode change kills the frame under way
  mdr_spi_frame u_spi (
    .clk        (REF_CLK),
    .rst_n      (NRST),
    .sck        (SCK),
    .scsn       (SCSN),
    .sdi        (SDI),
    .abort_i    (mode_chg), // [R02]
    .rd_data_i  (rd_data),
    .sdo_o      (SDO),
    .live_o     (spi_live),
    .rd_addr_o  (rd_addr),
    .wr_stb_o   (wr_stb),
    .wr_addr_o  (wr_addr),
    .wr_data_o  (wr_data),
    .wr_bytes_o (wr_bytes),
    .fail_o     (spi_fail)
  );

  // live status; off reads the reset pattern
  always_comb begin
    trx_sts = 8'h00;
    trx_sts[mdr_pkg::POS_TX_ACTIVE] = in_normal & TX_ACTIVE; // [R07]
    trx_sts[mdr_pkg::POS_SW_ERR] = in_off | SW_ERROR; // [R03]
    trx_sts[mdr_pkg::POS_SILENCE_STS] = in_off | BUS_SILENT; // [R03]
  end
  // read mux; unmapped addresses read zero
  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      mdr_pkg::ADDR_MODE_CTRL:  rd_data = mc_q;
      mdr_pkg::ADDR_MAIN_STS:   rd_data = main_q;
      mdr_pkg::ADDR_CAN_CTRL:   rd_data = can_q;
      mdr_pkg::ADDR_TRX_STS:    rd_data = trx_sts;
      mdr_pkg::ADDR_TRX_EN:     rd_data = trxen_q;
      mdr_pkg::ADDR_RATE:       rd_data = rate_q;
      mdr_pkg::ADDR_FRAME_CTRL: rd_data = frame_q;
      mdr_pkg::ADDR_WAKE_EN:    rd_data = wake_q;
      mdr_pkg::ADDR_EV_SUM:     rd_data = sum_q;
      mdr_pkg::ADDR_SYS_EV:     rd_data = sys_q;
      mdr_pkg::ADDR_TRX_EV:     rd_data = trx_q;
      mdr_pkg::ADDR_WAKE_EV:    rd_data = wpev_q;
      mdr_pkg::ADDR_ID:         rd_data = DEVICE_ID; // [R08]
      default: if (rd_addr[6:3] == mdr_pkg::ADDR_DMASK_HI) rd_data = dm_q[rd_addr[2:0]];
    endcase
  end

  // event sources, one bit each
  always_comb begin
    sys_set = 8'h00;
    trx_set = 8'h00;
    wp_set  = 8'h00;
    sys_set[mdr_pkg::POS_SERIAL_FAIL] = spi_fail; // [R10]
    sys_set[mdr_pkg::POS_OTW]         = EV_OTW;
    trx_set[mdr_pkg::POS_FRAME_ERR]   = EV_FRAME_ERR;
    trx_set[mdr_pkg::POS_SILENCE_EV]  = EV_BUS_SILENCE;
    trx_set[mdr_pkg::POS_FAIL_EV]     = EV_BUS_FAIL;
    trx_set[mdr_pkg::POS_WAKE_EV]     = EV_BUS_WAKE;
    wp_set[mdr_pkg::POS_RISE_EV]      = EV_WAKE_RISE;
    wp_set[mdr_pkg::POS_FALL_EV]      = EV_WAKE_FALL;
  end

  // next state: host writes, then events, then the mode table on top
  always_comb begin
    logic [7:0] a;
    logic [7:0] b;
    a = 8'h00;
    b = 8'h00;
    mc_d = mc_q; main_d = main_q; can_d = can_q; trxen_d = trxen_q; rate_d = rate_q;
    frame_d = frame_q; wake_d = wake_q; sum_d = sum_q; sys_d = sys_q; trx_d = trx_q;
    wpev_d = wpev_q; dm_d = dm_q;
    if (wr_stb && !mode_chg) begin // [R02]
      for (int k = 0; k < 3; k++) begin
        a = {1'b0, wr_addr} + 8'(k);
        b = wr_data[8*k +: 8];
        // bytes past the top of the map fall away silently
        if ((k < int'(wr_bytes)) && !a[7]) begin
          case (a[6:0])
            mdr_pkg::ADDR_MODE_CTRL:  mc_d    = b & mdr_pkg::WMASK_MODE;
            mdr_pkg::ADDR_CAN_CTRL:   can_d   = b & mdr_pkg::WMASK_CAN;
            mdr_pkg::ADDR_TRX_EN:     trxen_d = b & mdr_pkg::WMASK_TRXEN;
            mdr_pkg::ADDR_RATE:       rate_d  = b & mdr_pkg::WMASK_RATE;
            mdr_pkg::ADDR_FRAME_CTRL: frame_d = b & mdr_pkg::WMASK_FRAME;
            mdr_pkg::ADDR_WAKE_EN:    wake_d  = b & mdr_pkg::WMASK_WAKE;
            mdr_pkg::ADDR_EV_SUM:     sum_d   = sum_d & ~b;
            mdr_pkg::ADDR_SYS_EV:     sys_d   = sys_d & ~b;
            mdr_pkg::ADDR_TRX_EV:     trx_d   = trx_d & ~b;
            mdr_pkg::ADDR_WAKE_EV:    wpev_d  = wpev_d & ~b;
            default: if (a[6:3] == mdr_pkg::ADDR_DMASK_HI) dm_d[a[2:0]] = b; // identity ignored [R08]
          endcase
        end
      end
    end
    // sets land after the clears so a same-cycle event survives
    sys_d  = sys_d | sys_set;
    trx_d  = trx_d | trx_set;
    wpev_d = wpev_d | wp_set;
    sum_d[mdr_pkg::POS_SYS_SUM]     = sum_d[mdr_pkg::POS_SYS_SUM] | (|sys_set);
    sum_d[mdr_pkg::POS_TRX_SUM]     = sum_d[mdr_pkg::POS_TRX_SUM] | (|trx_set);
    sum_d[mdr_pkg::POS_WAKEPIN_SUM] = sum_d[mdr_pkg::POS_WAKEPIN_SUM] | (|wp_set);
    if (mode_chg) begin // [R01]
      case (MODE)
        mdr_pkg::MODE_STANDBY: mc_d = mdr_pkg::MC_STANDBY; // [R04]
        mdr_pkg::MODE_NORMAL: begin
          mc_d = mdr_pkg::MC_NORMAL; // [R04]
          main_d[mdr_pkg::POS_NOT_NORMAL] = 1'b0;
        end
        mdr_pkg::MODE_SLEEP: begin
          mc_d = mdr_pkg::MC_SLEEP; // [R04]
          main_d[mdr_pkg::POS_FORCED_SLEEP] = 1'b0; // [R06]
        end
        mdr_pkg::MODE_FSLEEP: begin
          // hardware clear here outranks any event of the same cycle
          mc_d   = mdr_pkg::MC_SLEEP; // [R04]
          sum_d  = 8'h00; // [R05]
          sys_d  = 8'h00; // [R05]
          trx_d  = 8'h00; // [R05]
          wpev_d = 8'h00; // [R05]
          can_d[mdr_pkg::POS_SW_CFG_OK] = 1'b0; // [R05]
          can_d[mdr_pkg::POS_SW_EN]     = 1'b0; // [R05]
          trxen_d[mdr_pkg::POS_WAKEUP_EN] = 1'b1; // [R06]
          wake_d[mdr_pkg::POS_RISE_EN]    = 1'b1; // [R06]
          wake_d[mdr_pkg::POS_FALL_EN]    = 1'b1; // [R06]
          main_d[mdr_pkg::POS_FORCED_SLEEP] = 1'b1; // [R06]
        end
        default: mc_d = mc_d; // overtemp leaves the field alone
      endcase
    end
    if (MODE == mdr_pkg::MODE_OFF) begin // [R03]
      mc_d = mdr_pkg::RST_MODE; main_d = mdr_pkg::RST_MAIN; can_d = 8'h00; trxen_d = 8'h00;
      rate_d = mdr_pkg::RST_RATE; frame_d = mdr_pkg::RST_FRAME; wake_d = 8'h00;
      sum_d = mdr_pkg::RST_SUM; sys_d = mdr_pkg::RST_SYS; trx_d = 8'h00; wpev_d = 8'h00;
      dm_d = {8{mdr_pkg::RST_DMASK}};
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin // [R03]
      mode_q <= mdr_pkg::MODE_OFF;
      mc_q <= mdr_pkg::RST_MODE; main_q <= mdr_pkg::RST_MAIN; can_q <= 8'h00; trxen_q <= 8'h00;
      rate_q <= mdr_pkg::RST_RATE; frame_q <= mdr_pkg::RST_FRAME; wake_q <= 8'h00;
      sum_q <= mdr_pkg::RST_SUM; sys_q <= mdr_pkg::RST_SYS; trx_q <= 8'h00; wpev_q <= 8'h00;
      dm_q <= {8{mdr_pkg::RST_DMASK}};
    end else begin
      mode_q <= MODE;
      mc_q <= mc_d; main_q <= main_d; can_q <= can_d; trxen_q <= trxen_d;
      rate_q <= rate_d; frame_q <= frame_d; wake_q <= wake_d;
      sum_q <= sum_d; sys_q <= sys_d; trx_q <= trx_d; wpev_q <= wpev_d;
      dm_q <= dm_d;
    end
  end

  // control outputs straight from register bits
  assign MODE_REQ     = mc_q[2:0];
  assign BUS_RATE     = rate_q[2:0];
  assign BUS_WAKE_EN  = trxen_q[mdr_pkg::POS_WAKEUP_EN];
  assign WAKE_RISE_EN = wake_q[mdr_pkg::POS_RISE_EN];
  assign WAKE_FALL_EN = wake_q[mdr_pkg::POS_FALL_EN];
  assign SEL_WAKE_EN  = can_q[mdr_pkg::POS_SW_EN];
  assign MATCH_DIS    = frame_q[6];

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  off_defaults_a: assert property (MODE == mdr_pkg::MODE_OFF |=> rate_q == 8'h05 && mc_q == 8'h04 &&
    dm_q == {8{8'hFF}} && sys_q == 8'h10 && sum_q == 8'h01 && MATCH_DIS) else $error("off defaults wrong"); // [R03]
  normal_entry_a: assert property (mode_chg && MODE == mdr_pkg::MODE_NORMAL |=> mc_q == 8'h07 &&
    !main_q[5]) else $error("normal entry bits wrong"); // [R04]
  sleep_entry_a: assert property (mode_chg && MODE == mdr_pkg::MODE_SLEEP |=> mc_q == 8'h01 && !main_q[7])
    else $error("sleep entry bits wrong"); // [R01]
  fsleep_clear_a: assert property (mode_chg && MODE == mdr_pkg::MODE_FSLEEP |=> sum_q == 8'h00 &&
    sys_q == 8'h00 && trx_q == 8'h00 && wpev_q == 8'h00 && !can_q[5] && !can_q[4])
    else $error("forced sleep left flags"); // [R05]
  fsleep_wake_a: assert property (mode_chg && MODE == mdr_pkg::MODE_FSLEEP |=> BUS_WAKE_EN &&
    WAKE_RISE_EN && WAKE_FALL_EN && main_q[7] && mc_q == 8'h01) else $error("forced sleep enables"); // [R06]
  overtemp_keep_a: assert property (mode_chg && MODE == mdr_pkg::MODE_OVERTEMP && !wr_stb |=> $stable(mc_q))
    else $error("overtemp moved mode field"); // [R04]
  tx_gate_a: assert property (!in_normal |-> !trx_sts[7]) else $error("tx status outside normal"); // [R07]
  id_fixed_a: assert property (rd_addr == 7'h7E |-> rd_data == DEVICE_ID) else $error("identity changed"); // [R08]
  fail_flag_a: assert property (spi_fail && MODE == mode_q && MODE != mdr_pkg::MODE_OFF |=> sys_q[1] && sum_q[0])
    else $error("serial failure not flagged"); // [R10]
  abort_drop_a: assert property (mode_chg && !SCSN |=> !spi_live) else $error("frame survived mode change"); // [R02]
  normal_cov_c: cover property (mode_q == mdr_pkg::MODE_STANDBY ##1 mode_q == mdr_pkg::MODE_NORMAL);
  fsleep_cov_c: cover property (mode_chg && MODE == mdr_pkg::MODE_FSLEEP);
  write_cov_c: cover property (wr_stb && wr_bytes == 2'h3);
  fail_cov_c: cover property (spi_fail);
endmodule : mdr_regs
`default_nettype wire

// >>> tb/mdr_host.sv
`timescale 1ns/1ps
`default_nettype none
module mdr_host (
  input  wire logic REF_CLK,
  input  wire logic SDO,
  output logic      SCK,
  output logic      SCSN,
  output logic      SDI
);
  // idle: deselected, serial clock parked low
  initial begin
    SCK = 1'b0;
    SCSN = 1'b1;
    SDI = 1'b0;
  end

  // one frame, msb first; long phases so every edge is seen by the sampler
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = 32'h0;
    @(posedge REF_CLK);
    SCSN <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      repeat (2) @(posedge REF_CLK);
      SCK <= 1'b1;
      SDI <= tx[31 - i]; // byte0 is address then read flag
      repeat (4) @(posedge REF_CLK);
      rx[31 - i] = SDO; // answer has settled well before the fall
      SCK <= 1'b0;
    end
    repeat (2) @(posedge REF_CLK);
    SCSN <= 1'b1;
    SDI <= ~SDI; // released line never shows the last bit
    repeat (2) @(posedge REF_CLK);
  endtask : xfer
endmodule : mdr_host
`default_nettype wire

// >>> tb/mdr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mdr_regs_tb;
  localparam logic [7:0] TEST_ID = 8'hC3; // arbitrary value
  localparam int         LIMIT   = 40000;
  logic        REF_CLK, NRST, SCK, SCSN, SDI, SDO, TX_ACTIVE, BUS_SILENT, SW_ERROR;
  logic [5:0]  MODE;
  logic [6:0]  ev;
  logic [2:0]  MODE_REQ, BUS_RATE;
  logic        BUS_WAKE_EN, WAKE_RISE_EN, WAKE_FALL_EN, SEL_WAKE_EN, MATCH_DIS;
  logic [23:0] d;
  int          errors, n_tests, cycles;

  mdr_host mdr_host_inst (.REF_CLK(REF_CLK), .SDO(SDO), .SCK(SCK), .SCSN(SCSN), .SDI(SDI));
  mdr_regs #(.DEVICE_ID(TEST_ID)) mdr_regs_inst (
    .REF_CLK(REF_CLK), .NRST(NRST), .SCK(SCK), .SCSN(SCSN), .SDI(SDI), .SDO(SDO), .MODE(MODE),
    .TX_ACTIVE(TX_ACTIVE), .BUS_SILENT(BUS_SILENT), .SW_ERROR(SW_ERROR), .EV_BUS_SILENCE(ev[0]),
    .EV_BUS_FAIL(ev[1]), .EV_BUS_WAKE(ev[2]), .EV_OTW(ev[3]), .EV_WAKE_RISE(ev[4]),
    .EV_WAKE_FALL(ev[5]), .EV_FRAME_ERR(ev[6]), .MODE_REQ(MODE_REQ), .BUS_RATE(BUS_RATE),
    .BUS_WAKE_EN(BUS_WAKE_EN), .WAKE_RISE_EN(WAKE_RISE_EN), .WAKE_FALL_EN(WAKE_FALL_EN),
    .SEL_WAKE_EN(SEL_WAKE_EN), .MATCH_DIS(MATCH_DIS));

  // free running reference clock
  initial REF_CLK = 1'b0;
  always #25 REF_CLK = ~REF_CLK;

  // hang guard, sized well above the longest expected run
  always @(posedge REF_CLK) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : cyc

  task automatic wr(input logic [6:0] a, input logic [23:0] v, input int nbits);
    logic [31:0] rx;
    mdr_host_inst.xfer({a, 1'b0, v}, nbits, rx);
    cyc(2);
  endtask : wr

  // junk on the data bytes must be ignored by a read
  task automatic rd(input logic [6:0] a, input int nbits);
    logic [31:0] rx;
    mdr_host_inst.xfer({a, 1'b1, 24'hA5A5A5}, nbits, rx);
    d = rx[23:0];
  endtask : rd

  task automatic rchk(input string what, input logic [6:0] a, input logic [7:0] exp);
    rd(a, 16);
    check(what, exp, d[23:16]);
  endtask : rchk

  task automatic set_mode(input logic [5:0] m);
    @(posedge REF_CLK);
    MODE <= m;
    cyc(3);
  endtask : set_mode

  function automatic logic [7:0] enables();
    return {3'h0, BUS_WAKE_EN, WAKE_RISE_EN, WAKE_FALL_EN, SEL_WAKE_EN, MATCH_DIS};
  endfunction : enables

  task automatic t_defaults();
    check("mode_req", 8'h04, {5'h00, MODE_REQ});
    check("bus_rate", 8'h05, {5'h00, BUS_RATE});
    check("enables", 8'h01, enables());
    set_mode(mdr_pkg::MODE_STANDBY);
    rchk("main_sts", mdr_pkg::ADDR_MAIN_STS, 8'h20);
    rchk("ev_sum", mdr_pkg::ADDR_EV_SUM, 8'h01);
    rchk("sys_ev", mdr_pkg::ADDR_SYS_EV, 8'h10);
    rchk("frame_ctrl", mdr_pkg::ADDR_FRAME_CTRL, 8'h40);
    rchk("trx_sts", mdr_pkg::ADDR_TRX_STS, 8'h00);
    rd({mdr_pkg::ADDR_DMASK_HI, 3'h0}, 32);
    check("dmask0", 8'hFF, d[23:16]);
    check("dmask2", 8'hFF, d[7:0]);
  endtask : t_defaults

  task automatic t_identity();
    rchk("id", mdr_pkg::ADDR_ID, TEST_ID);
    wr(mdr_pkg::ADDR_ID, 24'h000000, 16);
    rchk("id_after_write", mdr_pkg::ADDR_ID, TEST_ID);
  endtask : t_identity

  task automatic t_lengths();
    wr(mdr_pkg::ADDR_RATE, 24'h030000, 16);
    check("bus_rate", 8'h03, {5'h00, BUS_RATE});
    wr(mdr_pkg::ADDR_WAKE_EN, 24'h03FFFF, 24);
    check("enables", 8'h0D, enables());
    wr(mdr_pkg::ADDR_WAKE_EN, 24'h000000, 16);
    // twenty bits is not a legal write length
    wr(mdr_pkg::ADDR_RATE, 24'h060000, 20);
    check("bus_rate", 8'h03, {5'h00, BUS_RATE});
    rchk("sys_ev", mdr_pkg::ADDR_SYS_EV, 8'h12);
    rchk("ev_sum", mdr_pkg::ADDR_EV_SUM, 8'h01);
    check("bus_rate", 8'h03, {5'h00, BUS_RATE});
    wr(mdr_pkg::ADDR_SYS_EV, 24'h120000, 16);
    wr(mdr_pkg::ADDR_EV_SUM, 24'h010000, 16);
    rchk("sys_ev", mdr_pkg::ADDR_SYS_EV, 8'h00);
  endtask : t_lengths

  task automatic t_abort();
    fork
      wr(mdr_pkg::ADDR_RATE, 24'h010000, 16);
      begin
        cyc(40);
        MODE <= mdr_pkg::MODE_NORMAL;
      end
    join
    check("bus_rate", 8'h03, {5'h00, BUS_RATE});
    rchk("sys_ev", mdr_pkg::ADDR_SYS_EV, 8'h00);
    check("mode_req", 8'h07, {5'h00, MODE_REQ});
    rchk("main_sts", mdr_pkg::ADDR_MAIN_STS, 8'h00);
    @(posedge REF_CLK);
    TX_ACTIVE <= 1'b1;
    BUS_SILENT <= 1'b1;
    SW_ERROR <= 1'b1;
    cyc(2);
    rchk("trx_sts", mdr_pkg::ADDR_TRX_STS, 8'hC8);
  endtask : t_abort

  task automatic t_modes();
    set_mode(mdr_pkg::MODE_OVERTEMP);
    rchk("trx_sts", mdr_pkg::ADDR_TRX_STS, 8'h48);
    set_mode(mdr_pkg::MODE_SLEEP);
    rchk("trx_sts", mdr_pkg::ADDR_TRX_STS, 8'h48);
    check("mode_req", 8'h01, {5'h00, MODE_REQ});
    set_mode(mdr_pkg::MODE_STANDBY);
    rchk("trx_sts", mdr_pkg::ADDR_TRX_STS, 8'h48);
    check("mode_req", 8'h04, {5'h00, MODE_REQ});
  endtask : t_modes

  task automatic t_forced();
    wr(mdr_pkg::ADDR_CAN_CTRL, 24'h300000, 32);
    rchk("can_ctrl", mdr_pkg::ADDR_CAN_CTRL, 8'h30);
    @(posedge REF_CLK);
    ev <= 7'h7F;
    @(posedge REF_CLK);
    ev <= 7'h00;
    cyc(2);
    rd(mdr_pkg::ADDR_TRX_EV, 24);
    check("trx_ev", 8'h33, d[23:16]);
    check("wake_ev", 8'h03, d[15:8]);
    set_mode(mdr_pkg::MODE_FSLEEP);
    check("enables", 8'h1D, enables());
    check("mode_req", 8'h01, {5'h00, MODE_REQ});
    rd(mdr_pkg::ADDR_SYS_EV, 32);
    check("sys_ev", 8'h00, d[23:16]);
    check("trx_ev", 8'h00, d[7:0]);
    rchk("ev_sum", mdr_pkg::ADDR_EV_SUM, 8'h00);
    rchk("wake_ev", mdr_pkg::ADDR_WAKE_EV, 8'h00);
    rchk("can_ctrl", mdr_pkg::ADDR_CAN_CTRL, 8'h00);
    rchk("main_sts", mdr_pkg::ADDR_MAIN_STS, 8'h80);
    rchk("trx_sts", mdr_pkg::ADDR_TRX_STS, 8'h48);
    set_mode(mdr_pkg::MODE_SLEEP);
    rchk("main_sts", mdr_pkg::ADDR_MAIN_STS, 8'h00);
    check("enables", 8'h1D, enables());
  endtask : t_forced

  // main sequence: reset in off mode, then each scenario in turn
  initial begin
    errors = 0;
    n_tests = 0;
    cycles = 0;
    NRST = 1'b0;
    MODE = mdr_pkg::MODE_OFF;
    TX_ACTIVE = 1'b0;
    BUS_SILENT = 1'b0;
    SW_ERROR = 1'b0;
    ev = 7'h00;
    cyc(5);
    NRST <= 1'b1;
    cyc(2);
    t_defaults();
    t_identity();
    t_lengths();
    t_abort();
    t_modes();
    t_forced();
    report_and_stop();
  end
endmodule : mdr_regs_tb
`default_nettype wire
